// ==== verilog/logic_bitfield_pkg.sv ====
// shared constants and types of the logic and bit-field unit
package logic_bitfield_pkg;

   // ---------------------------------------------------------------
   // datapath widths and figures
   // ---------------------------------------------------------------
   localparam int ACC_W = 56;
   localparam int WORD_W = 24;
   localparam int EXT_W = 8;
   localparam int FIELD_W = 6;
   localparam int SHORT_IMM_W = 6;
   localparam int SHIFT_W = 5;
   localparam int REGSEL_W = 3;
   localparam int CMD_W = 17;
   localparam int OPCOUNT_W = 16;
   localparam logic [WORD_W-1:0] LEAD_BIAS = 24'h000009;
   localparam logic [FIELD_W-1:0] ACC_TOP_WIDTH = 6'h38;
   localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
   localparam logic [ACC_W-1:0] ACC_RESET = 56'h00000000000000;
   localparam logic [CMD_W-1:0] CMD_RESET = 17'h00000;
   localparam logic [OPCOUNT_W-1:0] OPCOUNT_RESET = 16'h0000;

   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_X_LOW = 8'h00;
   localparam logic [7:0] OFF_X_HIGH = 8'h04;
   localparam logic [7:0] OFF_Y_LOW = 8'h08;
   localparam logic [7:0] OFF_Y_HIGH = 8'h0c;
   localparam logic [7:0] OFF_A_LOW = 8'h10;
   localparam logic [7:0] OFF_A_MID = 8'h14;
   localparam logic [7:0] OFF_A_EXT = 8'h18;
   localparam logic [7:0] OFF_B_LOW = 8'h1c;
   localparam logic [7:0] OFF_B_MID = 8'h20;
   localparam logic [7:0] OFF_B_EXT = 8'h24;
   localparam logic [7:0] OFF_EXT_WORD = 8'h28;
   localparam logic [7:0] OFF_MODE = 8'h2c;
   localparam logic [7:0] OFF_COMMAND = 8'h30;
   localparam logic [7:0] OFF_STATUS = 8'h34;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_DEST_BIT = 4;
   localparam int CMD_SRC_BIT = 5;
   localparam int CMD_REG_LSB = 6;
   localparam int CMD_FORM_LSB = 9;
   localparam int CMD_IMM_LSB = 11;
   localparam int CTL_WIDTH_LSB = 12;
   localparam int CTL_OFFSET_LSB = 0;
   localparam int CTL16_WIDTH_LSB = 16;
   localparam int CTL16_OFFSET_LSB = 8;
   localparam int MODE_SIXTEEN_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_COUNT_LSB = 8;

   // ---------------------------------------------------------------
   // bus constants
   // ---------------------------------------------------------------
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam logic HRESP_OKAY = 1'b0;

   // ---------------------------------------------------------------
   // enumerations
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      op_nop = 4'b0000,
      op_and = 4'b0001,
      op_exclusive_or = 4'b0010,
      op_inclusive_or = 4'b0011,
      op_count_leading_bits = 4'b0100,
      op_signed_field_extract = 4'b0101,
      op_unsigned_field_extract = 4'b0110,
      op_field_insert = 4'b0111,
      op_logical_shift_left = 4'b1000,
      op_logical_shift_right = 4'b1001
   } op_t;

   typedef enum logic [1:0] {
      form_reg = 2'b00,
      form_short = 2'b01,
      form_long = 2'b10,
      form_single = 2'b11
   } form_t;

   typedef enum logic [REGSEL_W-1:0] {
      sel_x_low = 3'b000,
      sel_x_high = 3'b001,
      sel_y_low = 3'b010,
      sel_y_high = 3'b011,
      sel_a_mid = 3'b100,
      sel_b_mid = 3'b101
   } regsel_t;

   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_data = 2'b01
   } bus_state_t;

endpackage : logic_bitfield_pkg

// ==== verilog/leading_bit_counter.sv ====
// counts the run of bits equal to the top bit of a 56-bit value
`timescale 1ns/1ps
module leading_bit_counter
(
   input wire logic [logic_bitfield_pkg::ACC_W-1:0] i_value,
   output logic [logic_bitfield_pkg::FIELD_W-1:0] o_count
);

   logic run;

   always_comb
   begin
      o_count = '0;
      run = 1'b1;
      for (int i = logic_bitfield_pkg::ACC_W - 1; i >= 0; i--)
      begin
         if (run && (i_value[i] == i_value[logic_bitfield_pkg::ACC_W-1]))
         begin
            o_count = o_count + 6'h01;
         end
         else
         begin
            run = 1'b0;
         end
      end
   end

endmodule : leading_bit_counter

// ==== verilog/field_unit.sv ====
// bit-field extraction and insertion on 56-bit accumulators
`timescale 1ns/1ps
module field_unit
(
   input wire logic [logic_bitfield_pkg::ACC_W-1:0] i_src,
   input wire logic [logic_bitfield_pkg::ACC_W-1:0] i_dest,
   input wire logic [logic_bitfield_pkg::FIELD_W-1:0] i_width,
   input wire logic [logic_bitfield_pkg::FIELD_W-1:0] i_offset,
   input wire logic i_signed,
   output logic [logic_bitfield_pkg::ACC_W-1:0] o_extract,
   output logic [logic_bitfield_pkg::ACC_W-1:0] o_insert
);

   logic [logic_bitfield_pkg::ACC_W-1:0] mask;
   logic [logic_bitfield_pkg::ACC_W-1:0] field;
   logic [logic_bitfield_pkg::FIELD_W-1:0] top;

   // widths of 56 and above take the whole accumulator
   always_comb
   begin
      if (i_width >= logic_bitfield_pkg::ACC_TOP_WIDTH)
      begin
         mask = '1;
      end
      else
      begin
         mask = (56'h00000000000001 << i_width) - 56'h00000000000001;
      end
   end

   always_comb
   begin
      top = i_width - 6'h01;
      field = (i_src >> i_offset) & mask;
      o_extract = field;
      if (i_signed && (i_width != 6'h00) &&
         (i_width < logic_bitfield_pkg::ACC_TOP_WIDTH) && field[top])
      begin
         o_extract = field | ~mask;
      end
   end

   // bits pushed past bit 55 by a large offset are dropped
   always_comb
   begin
      o_insert = (i_dest & ~(mask << i_offset)) |
         ((i_src & mask) << i_offset);
   end

endmodule : field_unit

// ==== verilog/logic_bitfield_unit.sv ====
// logic and bit-field datapath with its AHB-Lite register slave
//
// Notes on behaviour
// (RULE1) and combines register, 6-bit short or 24-bit long operand
// (RULE2) exclusive or takes register, 6-bit short or 24-bit long operand
// (RULE3) inclusive or takes register, 6-bit short or 24-bit long operand
// (RULE4) bit 55 of the source picks counting zeros or ones
// (RULE5) top bit zero: 9 minus leading zeros into bits 47-24
// (RULE6) top bit one: 9 minus leading ones into the middle word
// (RULE7) extraction from second source, signed and unsigned variants
// (RULE8) normal mode: field width from control bits 17-12
// (RULE9) normal mode: field offset from control bits 5-0
// (RULE10) sixteen-bit mode: offset from bits 13-8, width 21-16
// (RULE11) control operand is a data register or the extension word
// (RULE12) insertion places low field of second source at the offset
// (RULE13) register control from four input regs or two middle words
// (RULE14) shift count immediate is 5-bit unsigned, zero to 23
// (RULE15) shift count may come from input regs or middle words
// (RULE16) count, extract and insert use either accumulator both ways
// (RULE17) destinations are 56-bit accumulators
// (RULE18) signed extraction sign-extends, unsigned fills zeros above
// (RULE19) shift without count moves one bit, vacated bits are zero
`timescale 1ns/1ps
module logic_bitfield_unit
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic_bitfield_pkg::bus_state_t bus_state_q;
   logic [7:0] addr_q;
   logic hit_q;
   logic wr_q;
   logic hreadyout_q;
   logic [31:0] hrdata_q;
   logic [logic_bitfield_pkg::WORD_W-1:0] in_reg_q [4];
   logic [logic_bitfield_pkg::ACC_W-1:0] acc_q [2];
   logic [logic_bitfield_pkg::WORD_W-1:0] ext_word_q;
   logic mode16_q;
   logic [logic_bitfield_pkg::CMD_W-1:0] cmd_q;
   logic exec_q;
   logic [logic_bitfield_pkg::OPCOUNT_W-1:0] op_count_q;

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   logic_bitfield_pkg::op_t op;
   logic_bitfield_pkg::form_t form;
   logic dest_sel;
   logic src_sel;
   logic [logic_bitfield_pkg::REGSEL_W-1:0] reg_sel;
   logic [logic_bitfield_pkg::SHORT_IMM_W-1:0] short_imm;

   assign op = logic_bitfield_pkg::op_t'(cmd_q[logic_bitfield_pkg::CMD_OP_LSB
      +: 4]);
   assign form = logic_bitfield_pkg::form_t'(
      cmd_q[logic_bitfield_pkg::CMD_FORM_LSB +: 2]);
   assign dest_sel = cmd_q[logic_bitfield_pkg::CMD_DEST_BIT];
   assign src_sel = cmd_q[logic_bitfield_pkg::CMD_SRC_BIT];
   assign reg_sel = cmd_q[logic_bitfield_pkg::CMD_REG_LSB +:
      logic_bitfield_pkg::REGSEL_W];
   assign short_imm = cmd_q[logic_bitfield_pkg::CMD_IMM_LSB +:
      logic_bitfield_pkg::SHORT_IMM_W];

   // ---------------------------------------------------------------
   // operand selection
   // ---------------------------------------------------------------
   logic [logic_bitfield_pkg::ACC_W-1:0] dest_val;
   logic [logic_bitfield_pkg::ACC_W-1:0] src_val;
   logic [logic_bitfield_pkg::WORD_W-1:0] reg_val;
   logic [logic_bitfield_pkg::WORD_W-1:0] logic_operand;
   logic [logic_bitfield_pkg::WORD_W-1:0] ctrl;
   logic [logic_bitfield_pkg::FIELD_W-1:0] fld_width;
   logic [logic_bitfield_pkg::FIELD_W-1:0] fld_offset;
   logic [logic_bitfield_pkg::SHIFT_W-1:0] shift_count;

   assign dest_val = acc_q[dest_sel]; // RULE16
   assign src_val = acc_q[src_sel]; // RULE16

   always_comb
   begin
      case (logic_bitfield_pkg::regsel_t'(reg_sel)) // RULE13 RULE15
         logic_bitfield_pkg::sel_x_low: reg_val = in_reg_q[0];
         logic_bitfield_pkg::sel_x_high: reg_val = in_reg_q[1];
         logic_bitfield_pkg::sel_y_low: reg_val = in_reg_q[2];
         logic_bitfield_pkg::sel_y_high: reg_val = in_reg_q[3];
         logic_bitfield_pkg::sel_a_mid: reg_val = acc_q[0][47:24];
         logic_bitfield_pkg::sel_b_mid: reg_val = acc_q[1][47:24];
         default: reg_val = '0;
      endcase
   end

   // short immediates sit zero-extended in the low bits of the word
   always_comb
   begin
      case (form) // RULE1 RULE2 RULE3
         logic_bitfield_pkg::form_short:
            logic_operand = {18'h00000, short_imm};
         logic_bitfield_pkg::form_long: logic_operand = ext_word_q;
         default: logic_operand = reg_val;
      endcase
   end

   // long form selects the immediate control word
   assign ctrl = (form == logic_bitfield_pkg::form_long) ? ext_word_q :
      reg_val; // RULE11

   always_comb
   begin
      if (mode16_q)
      begin
         fld_width = ctrl[logic_bitfield_pkg::CTL16_WIDTH_LSB +:
            logic_bitfield_pkg::FIELD_W]; // RULE10
         fld_offset = ctrl[logic_bitfield_pkg::CTL16_OFFSET_LSB +:
            logic_bitfield_pkg::FIELD_W]; // RULE10
      end
      else
      begin
         fld_width = ctrl[logic_bitfield_pkg::CTL_WIDTH_LSB +:
            logic_bitfield_pkg::FIELD_W]; // RULE8
         fld_offset = ctrl[logic_bitfield_pkg::CTL_OFFSET_LSB +:
            logic_bitfield_pkg::FIELD_W]; // RULE9
      end
   end

   // counts above 23 are not clamped; the word simply empties
   always_comb
   begin
      case (form)
         logic_bitfield_pkg::form_short:
            shift_count = short_imm[logic_bitfield_pkg::SHIFT_W-1:0]; // RULE14
         logic_bitfield_pkg::form_reg:
            shift_count = reg_val[logic_bitfield_pkg::SHIFT_W-1:0]; // RULE15
         default: shift_count = 5'h01; // RULE19
      endcase
   end

   // ---------------------------------------------------------------
   // datapath units
   // ---------------------------------------------------------------
   logic [logic_bitfield_pkg::FIELD_W-1:0] lead_count;
   logic [logic_bitfield_pkg::ACC_W-1:0] extract_val;
   logic [logic_bitfield_pkg::ACC_W-1:0] insert_val;
   logic [logic_bitfield_pkg::WORD_W-1:0] lead_val;

   leading_bit_counter i_leading_bit_counter
   (
      .i_value(src_val),
      .o_count(lead_count)
   );

   field_unit i_field_unit
   (
      .i_src(src_val),
      .i_dest(dest_val),
      .i_width(fld_width),
      .i_offset(fld_offset),
      .i_signed(op == logic_bitfield_pkg::op_signed_field_extract),
      .o_extract(extract_val),
      .o_insert(insert_val)
   );

   // the run counts bit 55 itself, whatever its value
   assign lead_val = logic_bitfield_pkg::LEAD_BIAS -
      {18'h00000, lead_count}; // RULE4 RULE5 RULE6

   // ---------------------------------------------------------------
   // result
   // ---------------------------------------------------------------
   logic [logic_bitfield_pkg::WORD_W-1:0] mid;
   logic [logic_bitfield_pkg::ACC_W-1:0] result;

   assign mid = dest_val[47:24];

   always_comb
   begin
      result = dest_val;
      case (op)
         logic_bitfield_pkg::op_and:
            result[47:24] = mid & logic_operand; // RULE1
         logic_bitfield_pkg::op_exclusive_or:
            result[47:24] = mid ^ logic_operand; // RULE2
         logic_bitfield_pkg::op_inclusive_or:
            result[47:24] = mid | logic_operand; // RULE3
         logic_bitfield_pkg::op_count_leading_bits:
            result = {{logic_bitfield_pkg::EXT_W{lead_val[23]}}, lead_val,
               24'h000000}; // RULE5 RULE6 RULE17
         logic_bitfield_pkg::op_signed_field_extract:
            result = extract_val; // RULE7 RULE18
         logic_bitfield_pkg::op_unsigned_field_extract:
            result = extract_val; // RULE7 RULE18
         logic_bitfield_pkg::op_field_insert:
            result = insert_val; // RULE12 RULE17
         logic_bitfield_pkg::op_logical_shift_left:
            result[47:24] = mid << shift_count; // RULE14 RULE19
         logic_bitfield_pkg::op_logical_shift_right:
            result[47:24] = mid >> shift_count; // RULE14 RULE19
         default: result = dest_val;
      endcase
   end

   // ---------------------------------------------------------------
   // AHB-Lite slave: one wait state on every transfer
   // ---------------------------------------------------------------
   logic bus_wr;
   logic bus_rd;

   assign bus_wr = (bus_state_q == logic_bitfield_pkg::bus_data) && wr_q &&
      hit_q;
   assign bus_rd = (bus_state_q == logic_bitfield_pkg::bus_data) && !wr_q;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         bus_state_q <= logic_bitfield_pkg::bus_idle;
         addr_q <= 8'h00;
         hit_q <= 1'b0;
         wr_q <= 1'b0;
         hreadyout_q <= 1'b1;
      end
      else if (i_ce)
      begin
         case (bus_state_q)
            logic_bitfield_pkg::bus_idle:
            begin
               if (i_hsel && i_htrans[1] && i_hready)
               begin
                  addr_q <= i_haddr[7:0];
                  // a narrow write is dropped, never treated as a read
                  hit_q <= (i_haddr[31:8] == 24'h000000) &&
                     (i_haddr[1:0] == 2'b00) && (!i_hwrite ||
                     (i_hsize == logic_bitfield_pkg::HSIZE_WORD));
                  wr_q <= i_hwrite;
                  hreadyout_q <= 1'b0;
                  bus_state_q <= logic_bitfield_pkg::bus_data;
               end
            end
            logic_bitfield_pkg::bus_data:
            begin
               hreadyout_q <= 1'b1;
               bus_state_q <= logic_bitfield_pkg::bus_idle;
            end
            default:
            begin
               hreadyout_q <= 1'b1;
               bus_state_q <= logic_bitfield_pkg::bus_idle;
            end
         endcase
      end
   end

   // unmapped offsets read as zero
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         hrdata_q <= 32'h00000000;
      end
      else if (i_ce && bus_rd)
      begin
         hrdata_q <= 32'h00000000;
         if (hit_q)
         begin
            case (addr_q)
               logic_bitfield_pkg::OFF_X_LOW: hrdata_q[23:0] <= in_reg_q[0];
               logic_bitfield_pkg::OFF_X_HIGH: hrdata_q[23:0] <= in_reg_q[1];
               logic_bitfield_pkg::OFF_Y_LOW: hrdata_q[23:0] <= in_reg_q[2];
               logic_bitfield_pkg::OFF_Y_HIGH: hrdata_q[23:0] <= in_reg_q[3];
               logic_bitfield_pkg::OFF_A_LOW: hrdata_q[23:0] <= acc_q[0][23:0];
               logic_bitfield_pkg::OFF_A_MID:
                  hrdata_q[23:0] <= acc_q[0][47:24];
               logic_bitfield_pkg::OFF_A_EXT: hrdata_q[7:0] <= acc_q[0][55:48];
               logic_bitfield_pkg::OFF_B_LOW: hrdata_q[23:0] <= acc_q[1][23:0];
               logic_bitfield_pkg::OFF_B_MID:
                  hrdata_q[23:0] <= acc_q[1][47:24];
               logic_bitfield_pkg::OFF_B_EXT: hrdata_q[7:0] <= acc_q[1][55:48];
               logic_bitfield_pkg::OFF_EXT_WORD: hrdata_q[23:0] <= ext_word_q;
               logic_bitfield_pkg::OFF_MODE:
                  hrdata_q[logic_bitfield_pkg::MODE_SIXTEEN_BIT] <= mode16_q;
               logic_bitfield_pkg::OFF_COMMAND: hrdata_q[16:0] <= cmd_q;
               logic_bitfield_pkg::OFF_STATUS:
               begin
                  hrdata_q[logic_bitfield_pkg::STAT_BUSY_BIT] <= exec_q;
                  hrdata_q[logic_bitfield_pkg::STAT_COUNT_LSB +:
                     logic_bitfield_pkg::OPCOUNT_W] <= op_count_q;
               end
               default: hrdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // input registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < 4; i++)
         begin
            in_reg_q[i] <= logic_bitfield_pkg::WORD_RESET;
         end
      end
      else if (i_ce && bus_wr)
      begin
         case (addr_q)
            logic_bitfield_pkg::OFF_X_LOW: in_reg_q[0] <= i_hwdata[23:0];
            logic_bitfield_pkg::OFF_X_HIGH: in_reg_q[1] <= i_hwdata[23:0];
            logic_bitfield_pkg::OFF_Y_LOW: in_reg_q[2] <= i_hwdata[23:0];
            logic_bitfield_pkg::OFF_Y_HIGH: in_reg_q[3] <= i_hwdata[23:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // accumulators: an executing command wins over a bus write
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         acc_q[0] <= logic_bitfield_pkg::ACC_RESET;
         acc_q[1] <= logic_bitfield_pkg::ACC_RESET;
      end
      else if (i_ce)
      begin
         if (exec_q)
         begin
            acc_q[dest_sel] <= result; // RULE16 RULE17
         end
         else if (bus_wr)
         begin
            case (addr_q)
               logic_bitfield_pkg::OFF_A_LOW: acc_q[0][23:0] <= i_hwdata[23:0];
               logic_bitfield_pkg::OFF_A_MID: acc_q[0][47:24] <= i_hwdata[23:0];
               logic_bitfield_pkg::OFF_A_EXT: acc_q[0][55:48] <= i_hwdata[7:0];
               logic_bitfield_pkg::OFF_B_LOW: acc_q[1][23:0] <= i_hwdata[23:0];
               logic_bitfield_pkg::OFF_B_MID: acc_q[1][47:24] <= i_hwdata[23:0];
               logic_bitfield_pkg::OFF_B_EXT: acc_q[1][55:48] <= i_hwdata[7:0];
               default: ;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration and command launch
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         ext_word_q <= logic_bitfield_pkg::WORD_RESET;
         mode16_q <= 1'b0;
         cmd_q <= logic_bitfield_pkg::CMD_RESET;
         exec_q <= 1'b0;
      end
      else if (i_ce)
      begin
         exec_q <= 1'b0;
         if (bus_wr)
         begin
            case (addr_q)
               logic_bitfield_pkg::OFF_EXT_WORD: ext_word_q <= i_hwdata[23:0];
               logic_bitfield_pkg::OFF_MODE:
                  mode16_q <= i_hwdata[logic_bitfield_pkg::MODE_SIXTEEN_BIT];
               logic_bitfield_pkg::OFF_COMMAND:
               begin
                  cmd_q <= i_hwdata[16:0];
                  exec_q <= 1'b1;
               end
               default: ;
            endcase
         end
      end
   end

   // counts executed commands, wraps silently
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         op_count_q <= logic_bitfield_pkg::OPCOUNT_RESET;
      end
      else if (i_ce && exec_q)
      begin
         op_count_q <= op_count_q + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_hreadyout = hreadyout_q;
   assign o_hresp = logic_bitfield_pkg::HRESP_OKAY;
   assign o_hrdata = hrdata_q;

endmodule : logic_bitfield_unit

// ==== bench/lbu_checker_assertions.sv ====
// bus-side assertions for the logic and bit-field unit
`timescale 1ns/1ps
module lbu_checker
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic [31:0] o_hrdata
);
   // ------------------------------------------------------------
   // transfer acceptance
   // ------------------------------------------------------------
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire logic tk = i_ce & i_hsel & i_htrans[1] & i_hready & o_hreadyout;
   resp_okay_a: assert property (o_hresp == 1'b0)
      else $error("response not okay");
   wait_state_a: assert property (tk |=> !o_hreadyout)
      else $error("no wait state");
   wait_end_a: assert property (!o_hreadyout && i_ce |=> o_hreadyout)
      else $error("wait state too long");
   idle_ready_a: assert property (o_hreadyout && !tk |=> o_hreadyout)
      else $error("ready dropped while idle");
   ce_freeze_a: assert property
      (!i_ce |=> $stable(o_hrdata) && $stable(o_hreadyout))
      else $error("state moved with clock enable low");
   rdata_cause_a: assert property ($changed(o_hrdata) |-> $past(!o_hreadyout))
      else $error("read data changed outside data phase");
   unmapped_zero_a: assert property
      (tk && !i_hwrite && i_haddr > 32'h34 |=> ##1 o_hrdata == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property
      (tk && !i_hwrite |=> ##1 o_hrdata[31:24] == 8'h00)
      else $error("upper read bits not zero");
   write_hold_a: assert property (tk && i_hwrite |=> ##1 $stable(o_hrdata))
      else $error("write disturbed read data");
endmodule : lbu_checker

// ==== bench/logic_bitfield_unit_bench.sv ====
// self-checking bench for the logic and bit-field unit
`timescale 1ns/1ps
module logic_bitfield_unit_bench;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, hw = 1'b0, rdy;
   logic [1:0] ht = 2'b00;
   logic [31:0] ha = 32'h0, wd = 32'h0, rdat, r;
   int error_cnt = 0, samples_checked = 0;
   always #10 clk = ~clk;
   logic_bitfield_unit i_logic_bitfield_unit (.i_clk(clk), .i_rst(rst),
      .i_ce(ce), .i_hsel(1'b1), .i_haddr(ha), .i_htrans(ht), .i_hwrite(hw),
      .i_hsize(3'b010), .i_hwdata(wd), .i_hready(rdy), .o_hreadyout(rdy),
      .o_hresp(), .o_hrdata(rdat));
   // ------------------------------------------------------------
   // bus tasks
   // ------------------------------------------------------------
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      ht <= 2'b10; hw <= w; ha <= {24'h0, a};
      do @(posedge clk); while (rdy !== 1'b1);
      ht <= 2'b00; wd <= d;
      do @(posedge clk); while (rdy !== 1'b1);
      r = rdat;
   endtask : xfer
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h exp %h", $time, seen, exp);
      end
   endtask : check
   task rc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      check(r, e);
   endtask : rc
   // op, dest, source, register select, form, short immediate
   task run(input int op, dst, src, rs, fm, im);
      wr(8'h30, op | dst << 4 | src << 5 | rs << 6 | fm << 9 | im << 11);
   endtask : run
   task sa(input logic [7:0] b, input logic [7:0] x, input logic [23:0] m,
      input logic [23:0] l);
      wr(b, l); wr(b + 8'h4, m); wr(b + 8'h8, x);
   endtask : sa
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_logic;
      logic [23:0] o [3];
      o = '{24'h0ff00f, 24'h00002a, 24'h5a5a5a};
      wr(8'h00, o[0]); wr(8'h28, o[2]);
      for (int op = 1; op < 4; op++)
         for (int f = 0; f < 3; f++)
         begin
            wr(8'h14, 24'hf0f0f0);
            run(op, 0, 0, 0, f, 6'h2a);
            rc(8'h14, op == 1 ? 24'hf0f0f0 & o[f] : op == 2 ?
               24'hf0f0f0 ^ o[f] : 24'hf0f0f0 | o[f]);
         end
   endtask : t_logic
   task t_clb;
      sa(8'h10, 8'h00, 24'h00ffff, 24'h123456);
      sa(8'h1c, 8'h00, 24'h0, 24'hffffff);
      run(4, 1, 0, 0, 0, 0);
      rc(8'h20, 24'hfffff9);
      rc(8'h24, 8'hff);
      sa(8'h1c, 8'hff, 24'hf00000, 24'h0);
      run(4, 0, 1, 0, 0, 0);
      rc(8'h14, 24'hfffffd);
   endtask : t_clb
   task t_field;
      sa(8'h10, 8'h00, 24'h0, 24'h000f50);
      wr(8'h28, 24'h008004);
      run(5, 1, 0, 0, 2, 0);
      rc(8'h1c, 24'hfffff5);
      wr(8'h0c, 24'h008004);
      run(6, 1, 0, 3, 0, 0);
      rc(8'h20, 24'h0);
      rc(8'h1c, 24'h0000f5);
      wr(8'h2c, 1); wr(8'h28, 24'h080400);
      run(6, 1, 0, 0, 2, 0);
      rc(8'h1c, 24'h0000f5);
      wr(8'h2c, 0); wr(8'h28, 24'h008004);
      sa(8'h1c, 8'h00, 24'h0, 24'hffffff);
      run(7, 1, 0, 0, 2, 0);
      rc(8'h1c, 24'hfff50f);
   endtask : t_field
   task sh(input int op, rs, fm, im, input logic [23:0] e);
      wr(8'h14, 24'h800001);
      run(op, 0, 0, rs, fm, im);
      rc(8'h14, e);
   endtask : sh
   task t_shift;
      wr(8'h04, 24'h000004);
      sh(8, 0, 1, 23, 24'h800000);
      sh(9, 0, 1, 23, 24'h000001);
      sh(8, 0, 1, 0, 24'h800001);
      sh(8, 0, 3, 0, 24'h000002);
      sh(9, 1, 0, 0, 24'h080000);
   endtask : t_shift
   task t_bus;
      wr(8'h40, 32'hffffffff);
      rc(8'h40, 32'h0);
      ce <= 1'b0;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      // twenty commands launched so far, unit idle
      rc(8'h34, 32'h00001400);
   endtask : t_bus
   task end_sim;
      $display("Checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   // generous: the whole run needs well under a thousand cycles
   initial
   begin
      #200000;
      error_cnt++;
      end_sim;
   end
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_logic; t_clb; t_field; t_shift; t_bus;
      end_sim;
   end
endmodule : logic_bitfield_unit_bench
bind logic_bitfield_unit lbu_checker i_lbu_checker (.*);
